// ===== tb/msp_serial_port_tb.sv
// self-checking bench for the primary serial channel
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_serial_port_tb import msp_pkg::*;;
   localparam int CLK_HZ = 192000;  // short bit periods
   logic        clk_i, arst_n_i, cpu_sel_i, cpu_we_i;
   logic [23:0] cpu_addr_i;
   logic [7:0]  cpu_wdata_i, cpu_rdata_o, rd, b, b2;
   logic        cpu_ack_o, rx_line, tx_line, req_n, clear_n, clear_seen;
   int          num_errors, cmp_count, seed, n, k;
   logic [7:0]  codes [8] = '{`MSP_CODE_110, `MSP_CODE_300, `MSP_CODE_600, `MSP_CODE_1200,
                              `MSP_CODE_2400, `MSP_CODE_4800, `MSP_CODE_9600, `MSP_CODE_19200};
   int          bauds [8] = '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};

   msp_serial_port #(.CLK_HZ(CLK_HZ)) msp_serial_port_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cpu_sel_i(cpu_sel_i), .cpu_we_i(cpu_we_i),
      .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
      .cpu_ack_o(cpu_ack_o), .primary_receive_line_i(rx_line),
      .primary_transmit_line_o(tx_line), .primary_request_line_n_o(req_n),
      .primary_clear_line_n_i(clear_n), .primary_clear_seen_o(clear_seen));
   msp_terminal_model term_i (
      .clk_i(clk_i), .tx_line_i(tx_line), .rx_line_o(rx_line), .clear_n_o(clear_n));

   // 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   function automatic int cycles_of(input int baud);
      return CLK_HZ / baud;
   endfunction : cycles_of

   function automatic logic [7:0] status_of(input logic rx, input logic txr, input logic idle);
      return {4'h0, idle, txr, 1'b0, rx};
   endfunction : status_of

   task automatic check(input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check

   // one bus access: strobe for one edge, ack and data taken at the next edge
   task automatic access(input logic we, input logic [23:0] a, input logic [7:0] wd);
      @(posedge clk_i);
      cpu_sel_i <= 1'b1;
      cpu_we_i <= we;
      cpu_addr_i <= a;
      cpu_wdata_i <= wd;
      @(posedge clk_i);
      cpu_sel_i <= 1'b0;
      @(posedge clk_i);
      rd = cpu_rdata_o;
      check(8'h01, {7'h00, cpu_ack_o});
   endtask : access

   task automatic wait_frames(input int target);
      for (int i = 0; i < 30000 && term_i.got_n < target; i++) @(posedge clk_i);
      if (term_i.got_n < target) begin
         num_errors++;
         $display("MISMATCH t=%0t frames exp=%h got=%h", $time, target, term_i.got_n);
      end
   endtask : wait_frames

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // hang guard
   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      seed = 2665;
      num_errors = 0;
      cmp_count = 0;
      arst_n_i = 1'b0;
      cpu_sel_i = 1'b0;
      cpu_we_i = 1'b0;
      cpu_addr_i = 24'h000000;
      cpu_wdata_i = 8'h00;
      repeat (3) @(posedge clk_i);
      check(8'h01, {7'h00, req_n});
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      check(8'h00, {7'h00, req_n});
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b0, 1'b1, 1'b1), rd);
      $display("test reset done");
      // every rate code, one random byte sent at each
      for (int i = 0; i < 8; i++) begin
         access(1'b1, `MSP_STATUS_ADDR, codes[i]);
         access(1'b0, `MSP_STATUS_ADDR, 8'h00);
         check(status_of(1'b0, 1'b1, 1'b1), rd);
         term_i.bit_cycles = cycles_of(bauds[i]);
         b = 8'($random(seed));
         n = term_i.got_n + 1;
         access(1'b1, `MSP_DATA_ADDR, b);
         wait_frames(n);
         check(b, term_i.got_byte);
         repeat (term_i.bit_cycles) @(posedge clk_i);
      end
      $display("test rates done");
      // unknown code ignored, back-to-back bytes keep order and hold tx ready low
      access(1'b1, `MSP_STATUS_ADDR, 8'h12);
      b = 8'($random(seed));
      b2 = 8'($random(seed));
      n = term_i.got_n + 2;
      access(1'b1, `MSP_DATA_ADDR, b);
      access(1'b1, `MSP_DATA_ADDR, b2);
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b0, 1'b0, 1'b0), rd);
      wait_frames(n - 1);
      check(b, term_i.got_byte);
      wait_frames(n);
      check(b2, term_i.got_byte);
      repeat (20) @(posedge clk_i);
      $display("test back to back tx done");
      // unmapped place reads zero; factory test addresses are never read
      access(1'b1, 24'hFE0001, 8'hA5);
      access(1'b0, 24'hFE0001, 8'h00);
      check(8'h00, rd);
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b0, 1'b1, 1'b1), rd);
      $display("test unmapped done");
      // single receive, then two waiting characters
      b = 8'($random(seed));
      term_i.send_byte(b);
      rd = 8'h00;
      for (k = 0; k < 300 && rd[0] !== 1'b1; k++) access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b1, 1'b1, 1'b1), rd);
      access(1'b0, `MSP_DATA_ADDR, 8'h00);
      check(b, rd);
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b0, 1'b1, 1'b1), rd);
      b = 8'h00;
      b2 = 8'hFF;
      term_i.send_byte(b);
      term_i.send_byte(b2);
      repeat (10) @(posedge clk_i);
      access(1'b0, `MSP_DATA_ADDR, 8'h00);
      check(b, rd);
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b1, 1'b1, 1'b1), rd);
      access(1'b0, `MSP_DATA_ADDR, 8'h00);
      check(b2, rd);
      access(1'b0, `MSP_STATUS_ADDR, 8'h00);
      check(status_of(1'b0, 1'b1, 1'b1), rd);
      $display("test receive done");
      // clear-to-send reported both ways
      term_i.set_clear(1'b0);
      repeat (2) @(posedge clk_i);
      #1;
      check(8'h01, {7'h00, clear_seen});
      term_i.set_clear(1'b1);
      repeat (2) @(posedge clk_i);
      #1;
      check(8'h00, {7'h00, clear_seen});
      check(8'h00, term_i.bad_n[7:0]);
      $display("test clear done");
      wrap_up();
   end
endmodule : msp_serial_port_tb

// ===== tb/msp_terminal_model.sv
// terminal model: serial sender and frame catcher facing the port
`timescale 1ns/1ps
module msp_terminal_model (
   input  wire logic clk_i,
   input  wire logic tx_line_i,
   output logic      rx_line_o,
   output logic      clear_n_o
);
   int         bit_cycles;   // cycles per bit, set by the bench
   int         got_n;        // frames caught
   int         bad_n;        // frames with a low stop bit
   logic [7:0] got_byte;
   logic [7:0] shift;

   // idle line high, clear-to-send off
   initial begin
      bit_cycles = 80;
      got_n = 0;
      bad_n = 0;
      got_byte = 8'h00;
      rx_line_o = 1'b1;
      clear_n_o = 1'b1;
   end

   // one 8N1 frame, lsb first, line left high after the stop bit
   task automatic send_byte(input logic [7:0] b);
      for (int i = -1; i < 9; i++) begin
         @(posedge clk_i);
         rx_line_o <= (i < 0) ? 1'b0 : ((i > 7) ? 1'b1 : b[i]);
         repeat (bit_cycles - 1) @(posedge clk_i);
      end
   endtask : send_byte

   // terminal grants or withdraws permission to send
   task automatic set_clear(input logic v);
      @(posedge clk_i);
      clear_n_o <= v;
   endtask : set_clear

   // catch frames from the port, sampling each bit mid-way
   always begin : catch_frames
      @(posedge clk_i iff tx_line_i === 1'b0);
      repeat (bit_cycles / 2) @(posedge clk_i);
      if (tx_line_i === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge clk_i);
            shift[i] = tx_line_i;
         end
         repeat (bit_cycles) @(posedge clk_i);
         if (tx_line_i === 1'b1) begin
            got_byte = shift;
            got_n++;
         end else begin
            bad_n++;
         end
      end
   end
endmodule : msp_terminal_model

// ===== verilog/msp_defines.svh
// constants for the memory mapped serial port
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH
`define MSP_ADDR_W       24
`define MSP_STATUS_ADDR  24'hFE0003
`define MSP_DATA_ADDR    24'hFE0007
`define MSP_TEST0_ADDR   24'hFE0005
`define MSP_TEST1_ADDR   24'hFE0015
`define MSP_ST_RX_READY  0
`define MSP_ST_TX_READY  2
`define MSP_ST_TX_EMPTY  3
`define MSP_CLK_HZ       100000000
`define MSP_CNT_W        20
`define MSP_RATE_RESET   8'h88
`define MSP_CODE_110     8'h11
`define MSP_CODE_300     8'h44
`define MSP_CODE_600     8'h55
`define MSP_CODE_1200    8'h66
`define MSP_CODE_2400    8'h88
`define MSP_CODE_4800    8'h99
`define MSP_CODE_9600    8'hBB
`define MSP_CODE_19200   8'hCC
`define MSP_BAUD_110     110
`define MSP_BAUD_300     300
`define MSP_BAUD_600     600
`define MSP_BAUD_1200    1200
`define MSP_BAUD_2400    2400
`define MSP_BAUD_4800    4800
`define MSP_BAUD_9600    9600
`define MSP_BAUD_19200   19200
`endif

// ===== verilog/msp_pkg.sv
// types shared by the serial port modules
package msp_pkg;
   typedef enum logic [1:0] {
      MSP_TX_IDLE  = 2'b00,
      MSP_TX_START = 2'b01,
      MSP_TX_DATA  = 2'b10,
      MSP_TX_STOP  = 2'b11
   } msp_tx_state_type;
   typedef enum logic [1:0] {
      MSP_RX_IDLE  = 2'b00,
      MSP_RX_START = 2'b01,
      MSP_RX_DATA  = 2'b10,
      MSP_RX_STOP  = 2'b11
   } msp_rx_state_type;
endpackage : msp_pkg

// ===== verilog/msp_rx.sv
// serial receiver: start bit check, eight data bits lsb first, stop bit
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_rx
   import msp_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic [`MSP_CNT_W-1:0] bit_cycles_i,
   input  wire logic                  primary_receive_line_i,
   output logic                       rx_valid_o,
   output logic [7:0]                 rx_data_o
);
   msp_rx_state_type      state_q, state_d;
   logic [`MSP_CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0]            bitn_q, bitn_d;
   logic [7:0]            shift_q, shift_d, data_q, data_d;
   logic                  valid_q, valid_d;

   // next state of the receive sequencer
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      bitn_d  = bitn_q;
      shift_d = shift_q;
      data_d  = data_q;
      valid_d = 1'b0;
      case (state_q)
         MSP_RX_IDLE: begin
            if (!primary_receive_line_i) begin
               state_d = MSP_RX_START;
               cnt_d   = bit_cycles_i >> 1; // sample mid bit
            end
         end
         MSP_RX_START: begin
            if (cnt_q == '0) begin
               if (!primary_receive_line_i) begin
                  state_d = MSP_RX_DATA;
                  cnt_d   = bit_cycles_i - `MSP_CNT_W'(1);
                  bitn_d  = 3'h0;
               end else begin
                  state_d = MSP_RX_IDLE; // glitch, not a start bit
               end
            end else begin
               cnt_d = cnt_q - `MSP_CNT_W'(1);
            end
         end
         MSP_RX_DATA: begin
            if (cnt_q == '0) begin
               shift_d = {primary_receive_line_i, shift_q[7:1]};
               cnt_d   = bit_cycles_i - `MSP_CNT_W'(1);
               bitn_d  = bitn_q + 3'h1;
               if (bitn_q == 3'h7) begin
                  state_d = MSP_RX_STOP;
               end
            end else begin
               cnt_d = cnt_q - `MSP_CNT_W'(1);
            end
         end
         MSP_RX_STOP: begin
            if (cnt_q == '0) begin
               state_d = MSP_RX_IDLE;
               if (primary_receive_line_i) begin
                  valid_d = 1'b1; // framing errors are dropped
                  data_d  = shift_q;
               end
            end else begin
               cnt_d = cnt_q - `MSP_CNT_W'(1);
            end
         end
         default: state_d = MSP_RX_IDLE;
      endcase
   end

   // receive registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= MSP_RX_IDLE;
         cnt_q   <= '0;
         bitn_q  <= 3'h0;
         shift_q <= 8'h00;
         data_q  <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         bitn_q  <= bitn_d;
         shift_q <= shift_d;
         data_q  <= data_d;
         valid_q <= valid_d;
      end
   end

   assign rx_valid_o = valid_q;
   assign rx_data_o  = data_q;
endmodule : msp_rx

// ===== verilog/msp_serial_port.sv
// primary serial channel with data and status/rate registers
//
// Notes on behaviour
// - status bit 0 is set while a received character waits in data register
// - status bit 2 is set while the transmitter can take a new character
// - a byte written to the data register is sent out on the transmit line
// - reading the data register returns the oldest waiting received character
// - writing the status address selects bit rate; reads still return status
// - codes 11,44,55,66,88,99,BB,CC select 110 up to 19200 baud
// - a request-to-send output is driven towards the terminal
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_serial_port
   import msp_pkg::*;
#(
   parameter int CLK_HZ = `MSP_CLK_HZ
) (
   input  wire logic                   clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   cpu_sel_i,
   input  wire logic                   cpu_we_i,
   input  wire logic [`MSP_ADDR_W-1:0] cpu_addr_i,
   input  wire logic [7:0]             cpu_wdata_i,
   output logic [7:0]                  cpu_rdata_o,
   output logic                        cpu_ack_o,
   input  wire logic                   primary_receive_line_i,
   output logic                        primary_transmit_line_o,
   output logic                        primary_request_line_n_o,
   input  wire logic                   primary_clear_line_n_i,
   output logic                        primary_clear_seen_o
);
   // bit period in clock cycles for a rate code
   function automatic logic [`MSP_CNT_W-1:0] rate_cycles(input logic [7:0] code);
      int b;
      b = `MSP_BAUD_2400;
      case (code)
         `MSP_CODE_110:   b = `MSP_BAUD_110;
         `MSP_CODE_300:   b = `MSP_BAUD_300;
         `MSP_CODE_600:   b = `MSP_BAUD_600;
         `MSP_CODE_1200:  b = `MSP_BAUD_1200;
         `MSP_CODE_2400:  b = `MSP_BAUD_2400;
         `MSP_CODE_4800:  b = `MSP_BAUD_4800;
         `MSP_CODE_9600:  b = `MSP_BAUD_9600;
         `MSP_CODE_19200: b = `MSP_BAUD_19200;
         default:         b = `MSP_BAUD_2400;
      endcase
      return `MSP_CNT_W'(CLK_HZ / b);
   endfunction : rate_cycles

   // true for the eight legal rate codes
   function automatic logic rate_ok(input logic [7:0] code);
      case (code)
         `MSP_CODE_110, `MSP_CODE_300, `MSP_CODE_600, `MSP_CODE_1200,
         `MSP_CODE_2400, `MSP_CODE_4800, `MSP_CODE_9600,
         `MSP_CODE_19200: rate_ok = 1'b1;
         default:         rate_ok = 1'b0;
      endcase
   endfunction : rate_ok

   logic                  rd_data, wr_data, rd_stat, wr_stat;
   logic [`MSP_CNT_W-1:0] bit_cycles;
   logic                  rx_valid;
   logic [7:0]            rx_byte, status;
   logic [7:0]            rate_q, rate_d;
   logic [7:0]            rx_data_q, rx_data_d, rx_hold_q, rx_hold_d;
   logic                  rx_ready_q, rx_ready_d, hold_valid_q, hold_valid_d;
   logic [7:0]            rdata_q, rdata_d;
   logic                  ack_q, rts_q, cts_q;
   msp_tx_state_type      tx_state_q, tx_state_d;
   logic [`MSP_CNT_W-1:0] tx_cnt_q, tx_cnt_d;
   logic [2:0]            tx_bitn_q, tx_bitn_d;
   logic [7:0]            tx_shift_q, tx_shift_d, tx_hold_q, tx_hold_d;
   logic                  tx_full_q, tx_full_d, txd_q, txd_d;

   // access decode; other addresses read zero with no side effect
   assign rd_data = cpu_sel_i && !cpu_we_i && (cpu_addr_i == `MSP_DATA_ADDR);
   assign wr_data = cpu_sel_i && cpu_we_i && (cpu_addr_i == `MSP_DATA_ADDR);
   assign rd_stat = cpu_sel_i && !cpu_we_i && (cpu_addr_i == `MSP_STATUS_ADDR);
   assign wr_stat = cpu_sel_i && cpu_we_i && (cpu_addr_i == `MSP_STATUS_ADDR);
   assign bit_cycles = rate_cycles(rate_q);

   // status byte
   always_comb begin
      status = 8'h00;
      status[`MSP_ST_RX_READY] = rx_ready_q;
      status[`MSP_ST_TX_READY] = !tx_full_q;
      status[`MSP_ST_TX_EMPTY] = !tx_full_q && (tx_state_q == MSP_TX_IDLE);
   end

   msp_rx u_rx (
      .clk_i                  (clk_i),
      .arst_n_i               (arst_n_i),
      .bit_cycles_i           (bit_cycles),
      .primary_receive_line_i (primary_receive_line_i),
      .rx_valid_o             (rx_valid),
      .rx_data_o              (rx_byte)
   );

   // rate select, read data and receive buffering
   always_comb begin
      rate_d       = rate_q;
      rdata_d      = 8'h00;
      rx_data_d    = rx_data_q;
      rx_hold_d    = rx_hold_q;
      rx_ready_d   = rx_ready_q;
      hold_valid_d = hold_valid_q;
      if (wr_stat && rate_ok(cpu_wdata_i)) begin
         rate_d = cpu_wdata_i;
      end
      if (rd_stat) begin
         rdata_d = status;
      end else if (rd_data) begin
         rdata_d = rx_data_q;
      end
      if (rd_data) begin
         if (hold_valid_q) begin
            rx_data_d    = rx_hold_q;
            hold_valid_d = 1'b0;
         end else begin
            rx_ready_d = 1'b0;
         end
      end
      // a new character wins over the clear of the same cycle
      if (rx_valid) begin
         if (rx_ready_d) begin
            rx_hold_d    = rx_byte;
            hold_valid_d = 1'b1;
         end else begin
            rx_data_d  = rx_byte;
            rx_ready_d = 1'b1;
         end
      end
   end

   // transmit holding register and shifter
   always_comb begin
      tx_state_d = tx_state_q;
      tx_cnt_d   = tx_cnt_q;
      tx_bitn_d  = tx_bitn_q;
      tx_shift_d = tx_shift_q;
      tx_hold_d  = tx_hold_q;
      tx_full_d  = tx_full_q;
      txd_d      = txd_q;
      case (tx_state_q)
         MSP_TX_IDLE: begin
            txd_d = 1'b1;
            if (tx_full_q) begin
               tx_shift_d = tx_hold_q;
               tx_full_d  = 1'b0;
               tx_state_d = MSP_TX_START;
               tx_cnt_d   = bit_cycles - `MSP_CNT_W'(1);
               txd_d      = 1'b0;
            end
         end
         MSP_TX_START: begin
            if (tx_cnt_q == '0) begin
               tx_state_d = MSP_TX_DATA;
               tx_cnt_d   = bit_cycles - `MSP_CNT_W'(1);
               tx_bitn_d  = 3'h0;
               txd_d      = tx_shift_q[0];
            end else begin
               tx_cnt_d = tx_cnt_q - `MSP_CNT_W'(1);
            end
         end
         MSP_TX_DATA: begin
            if (tx_cnt_q == '0) begin
               tx_cnt_d = bit_cycles - `MSP_CNT_W'(1);
               if (tx_bitn_q == 3'h7) begin
                  tx_state_d = MSP_TX_STOP;
                  txd_d      = 1'b1;
               end else begin
                  tx_shift_d = {1'b0, tx_shift_q[7:1]};
                  tx_bitn_d  = tx_bitn_q + 3'h1;
                  txd_d      = tx_shift_q[1];
               end
            end else begin
               tx_cnt_d = tx_cnt_q - `MSP_CNT_W'(1);
            end
         end
         MSP_TX_STOP: begin
            if (tx_cnt_q == '0) begin
               tx_state_d = MSP_TX_IDLE;
            end else begin
               tx_cnt_d = tx_cnt_q - `MSP_CNT_W'(1);
            end
         end
         default: tx_state_d = MSP_TX_IDLE;
      endcase
      // a write wins over the load of the same cycle
      if (wr_data) begin
         tx_hold_d = cpu_wdata_i;
         tx_full_d = 1'b1;
      end
   end

   // all registers of the channel outside the msp_rx receiver
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rate_q       <= `MSP_RATE_RESET;
         rdata_q      <= 8'h00;
         ack_q        <= 1'b0;
         rx_data_q    <= 8'h00;
         rx_hold_q    <= 8'h00;
         rx_ready_q   <= 1'b0;
         hold_valid_q <= 1'b0;
         tx_state_q   <= MSP_TX_IDLE;
         tx_cnt_q     <= '0;
         tx_bitn_q    <= 3'h0;
         tx_shift_q   <= 8'h00;
         tx_hold_q    <= 8'h00;
         tx_full_q    <= 1'b0;
         txd_q        <= 1'b1;
         rts_q        <= 1'b1;
         cts_q        <= 1'b0;
      end else begin
         rate_q       <= rate_d;
         rdata_q      <= rdata_d;
         ack_q        <= cpu_sel_i;
         rx_data_q    <= rx_data_d;
         rx_hold_q    <= rx_hold_d;
         rx_ready_q   <= rx_ready_d;
         hold_valid_q <= hold_valid_d;
         tx_state_q   <= tx_state_d;
         tx_cnt_q     <= tx_cnt_d;
         tx_bitn_q    <= tx_bitn_d;
         tx_shift_q   <= tx_shift_d;
         tx_hold_q    <= tx_hold_d;
         tx_full_q    <= tx_full_d;
         txd_q        <= txd_d;
         rts_q        <= 1'b0;
         cts_q        <= !primary_clear_line_n_i;
      end
   end

   assign cpu_rdata_o              = rdata_q;
   assign cpu_ack_o                = ack_q;
   assign primary_transmit_line_o  = txd_q;
   assign primary_request_line_n_o = rts_q;
   assign primary_clear_seen_o     = cts_q;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_rx_flag;
      rx_valid |=> rx_ready_q;
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("rx flag not set");

   property p_tx_ready;
      rd_stat |=> cpu_rdata_o[`MSP_ST_TX_READY] == !$past(tx_full_q);
   endproperty
   a_tx_ready: assert property (p_tx_ready) else $error("tx ready bit wrong");

   property p_tx_start;
      wr_data && !tx_full_q && tx_state_q == MSP_TX_IDLE
         |=> tx_full_q ##1 (!primary_transmit_line_o && tx_shift_q == $past(cpu_wdata_i, 2));
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("no start bit");

   property p_rx_read;
      rd_data |=> cpu_rdata_o == $past(rx_data_q) && cpu_ack_o;
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("bad read data");

   property p_rate_wr;
      wr_stat && rate_ok(cpu_wdata_i)
         |=> rate_q == $past(cpu_wdata_i) && rx_ready_q == ($past(rx_ready_q) || $past(rx_valid));
   endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate not taken");

   property p_rate_map;
      rate_q == `MSP_CODE_9600 |-> bit_cycles == `MSP_CNT_W'(CLK_HZ / `MSP_BAUD_9600);
   endproperty
   a_rate_map: assert property (p_rate_map) else $error("rate map wrong");

   property p_rts;
      ##2 1'b1 |-> !primary_request_line_n_o; // reset value still sampled on first edge
   endproperty
   a_rts: assert property (p_rts) else $error("request line idle");

   property p_rx_clear;
      rd_data && !hold_valid_q && !rx_valid |=> !rx_ready_q;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("flag not cleared");

   property p_rx_keep;
      rd_data && hold_valid_q |=> rx_ready_q && rx_data_q == $past(rx_hold_q);
   endproperty
   a_rx_keep: assert property (p_rx_keep) else $error("waiting char lost");

   c_rx_char: cover property (rx_valid ##[1:20] rd_data);
   c_tx_frame: cover property (tx_state_q == MSP_TX_STOP ##1 tx_state_q == MSP_TX_IDLE);
   c_rate_set: cover property (wr_stat && rate_ok(cpu_wdata_i));
endmodule : msp_serial_port
